// ### src/spi_core.sv
`timescale 1ns/1ps
module spi_core
  import spi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic cpu_wait,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic ss_in_n,
  output logic ss_out_n,
  output logic ss_oe_n
);
  import spi_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // registers and pin synchronisers
  // map: 0 control one, 1 control two, 2 baud, 3 status, 4 data,
  // 5 interrupt mask, 6 interrupt flags; 7 reads zero
  // control one: b6 enable, b4 master, b3 clock idle high, b2 phase,
  // b1 select output enable, b0 lsb first
  // control two: b4 fault detect enable, b3 bidir output enable,
  // b1 halt in wait, b0 single wire
  // baud: b6:4 prescale select, b2:0 rate divisor select
  // status: b7 receive full, b5 transmit empty, b4 mode fault
  // interrupt flags (write one to clear): b0 byte done, b1 mode fault
  // limitation: the input synchroniser costs two bus cycles, so a master
  // reading its data pin needs a half period of at least three bus cycles
  logic [7:0] ctrl1_ff;
  logic [7:0] ctrl2_ff;
  logic [7:0] baud_ff;
  logic [7:0] txd_ff;
  logic [7:0] rxd_ff;
  logic [7:0] imask_ff;
  logic [7:0] iflag_ff;
  logic rxf_ff;
  logic txe_ff;
  logic modf_ff;
  // pin samples: b2 select, b0 clock (b1 spare)
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic sck_d_ff;
  state_t st_ff;
  state_t nxt_st;
  // prescaler and power-of-two divider counts
  logic [2:0] pre_ff;
  logic [7:0] div_ff;
  // shift clock edges within a byte, sixteen per byte
  logic [3:0] edge_ff;
  logic [7:0] sh_ff;
  logic smp_ff;
  logic sclk_ff;
  logic ss_drv_ff;
  logic mo_ff;
  logic mi_ff;
  logic sck_oe_ff;
  logic ss_oe_ff;

  // raw pin bits pass two flops before use
  // the second stage alone feeds logic; the first is never read elsewhere
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      // idle pin levels, so no false select or clock edge after reset
      s1_ff <= 3'h4;
      s2_ff <= 3'h4;
    end
    else if (clk_en)
    begin
      s1_ff <= {ss_in_n, 1'b0, sck_in};
      s2_ff <= s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode and mode wires
  // halt in wait gates only the transfer logic; the register port keeps
  // answering so software can still reconfigure while the core sleeps
  wire run = clk_en && !(cpu_wait && ctrl2_ff[C2_SWAI]);
  wire enabled = ctrl1_ff[C1_EN];
  wire master = ctrl1_ff[C1_MASTER_SELECT];
  wire clock_phase = ctrl1_ff[C1_CLOCK_PHASE];
  wire cpol = ctrl1_ff[C1_CPOL];
  wire lsbf = ctrl1_ff[C1_LSBFE];
  wire bidir = ctrl2_ff[C2_SINGLE_WIRE_SELECT];
  wire ss_used = master && ctrl2_ff[C2_MODF];
  wire ss_is_out = ss_used && ctrl1_ff[C1_SELECT_OUTPUT_ENABLE];
  wire ss_is_fault = ss_used && !ctrl1_ff[C1_SELECT_OUTPUT_ENABLE];
  wire ss_sync_n = s2_ff[2];
  wire sck_sync = s2_ff[0] ^ cpol;
  wire sl_sel = enabled && !master && !ss_sync_n;
  // single-wire: master reads its own data pin, slave likewise
  logic mosi_s1_ff;
  logic mosi_s2_ff;
  logic miso_s1_ff;
  logic miso_s2_ff;
  wire din = master ? (bidir ? mosi_s2_ff : miso_s2_ff) : (bidir ? miso_s2_ff : mosi_s2_ff);
  // write decode; writes to status and unmapped addresses hit nothing
  wire wr_ctrl1 = wr_stb && addr == ADDR_CTRL1;
  wire wr_ctrl2 = wr_stb && addr == ADDR_CTRL2;
  wire wr_baud = wr_stb && addr == ADDR_BAUD;
  wire wr_data = wr_stb && addr == ADDR_DATA;
  wire wr_imask = wr_stb && addr == ADDR_IMASK;
  wire wr_iflag = wr_stb && addr == ADDR_IFLAG;
  wire rd_data = rd_stb && addr == ADDR_DATA;
  wire [7:0] status_val = {rxf_ff, 1'b0, txe_ff, modf_ff, 4'h0} & ST_IMPL_MASK;
  wire fault = ss_is_fault && enabled && !ss_sync_n;

  // data pins, two stages each; only the second stage is read
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mosi_s1_ff <= 1'b0;
      mosi_s2_ff <= 1'b0;
      miso_s1_ff <= 1'b0;
      miso_s2_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      mosi_s1_ff <= mosi_in;
      mosi_s2_ff <= mosi_s1_ff;
      miso_s1_ff <= miso_in;
      miso_s2_ff <= miso_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // baud generator: prescale then power-of-two divide
  // half bit period is (prescale + 1) * 2^rate bus cycles; counters run
  // only while a master byte is in progress so each byte starts in phase
  wire pre_tc = pre_ff == baud_ff[6:4];
  // last count of the divider, 2^rate - 1
  wire [7:0] half_lim = 8'((9'h1 << baud_ff[2:0]) - 9'h1);
  wire half_tick = run && pre_tc && div_ff == half_lim;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_ff <= 3'h0;
      div_ff <= 8'h00;
    end
    else if (run)
    begin
      // counts hold, not clear, while frozen so wait does not stretch a bit
      if (master && st_ff != IDLE)
      begin
        pre_ff <= pre_tc ? 3'h0 : pre_ff + 3'h1;
        if (pre_tc)
          div_ff <= (div_ff == half_lim) ? 8'h00 : div_ff + 8'h01;
      end
      else
      begin
        pre_ff <= 3'h0;
        div_ff <= 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // slave edge detect on the synchronised clock
  // the delayed sample resets to the idle clock level, so leaving reset
  // does not look like an edge
  wire sck_rise = sck_sync && !sck_d_ff;
  wire sck_fall = !sck_sync && sck_d_ff;
  wire sl_edge = sl_sel && (sck_rise || sck_fall);

  // master sequence: lead half period, 16 edges, trail half period
  // lead: select low, counting one half period before the first edge
  // shift: sixteen edges, the first ending the lead half period
  // trail: one more half period before select returns high
  // a fault from the select pin drops straight back to idle
  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      IDLE: if (master && enabled && !txe_ff && !fault) nxt_st = LEAD;
      LEAD: if (half_tick) nxt_st = SHIFT;
      SHIFT: if (half_tick && edge_ff == 4'hF) nxt_st = TRAIL;
      TRAIL: if (half_tick) nxt_st = IDLE;
      default: nxt_st = IDLE;
    endcase
    if (fault)
      nxt_st = IDLE;
  end

  // the tick that ends the lead half period is already the first edge
  wire m_edge = (st_ff == LEAD || st_ff == SHIFT) && half_tick;
  wire any_edge = master ? m_edge : sl_edge;
  // odd edges drive, even edges sample for phase 1; reversed for phase 0
  wire smp_edge = any_edge && (edge_ff[0] ^ !clock_phase);
  wire drv_edge = any_edge && !(edge_ff[0] ^ !clock_phase);
  wire last_edge = any_edge && edge_ff == 4'hF;
  // shift toward the chosen end, taking the bit sampled last
  wire [7:0] sh_shift = lsbf ? {smp_ff, sh_ff[7:1]} : {sh_ff[6:0], smp_ff};
  wire out_bit = lsbf ? sh_ff[0] : sh_ff[7];
  wire sl_start = sl_sel && edge_ff == 4'h0 && !txe_ff;
  // phase 1 samples on the last edge, so the final bit comes from the pin
  wire [7:0] sh_last = clock_phase ? (lsbf ? {din, sh_ff[7:1]} : {sh_ff[6:0], din}) : sh_shift;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_ff <= IDLE;
      edge_ff <= 4'h0;
      sh_ff <= 8'h00;
      smp_ff <= 1'b0;
      sck_d_ff <= 1'b0;
    end
    else if (run)
    begin
      st_ff <= nxt_st;
      sck_d_ff <= sck_sync;
      // a slave counts edges only while its select input is low
      if (!master && ss_sync_n)
        edge_ff <= 4'h0; // select high aborts a slave byte
      else if (any_edge)
        edge_ff <= edge_ff + 4'h1; // wraps: next byte keeps going
      // load the shifter as a byte is launched, master or slave
      if ((st_ff == IDLE && nxt_st == LEAD) || sl_start)
        sh_ff <= txd_ff;
      else if (drv_edge && edge_ff != 4'h0)
        sh_ff <= sh_shift;
      if (smp_edge)
        smp_ff <= din;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pins; output enables are active low
  // the enables are registered too, so every enable leaves from a flop
  // while the data lines follow the shifter's outgoing bit (bit 7, or bit 0 lsb first) directly
  wire drv_ok = !bidir || ctrl2_ff[C2_BIDIR_OUTPUT_ENABLE];
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_ff <= 1'b0;
      ss_drv_ff <= 1'b1;
      mo_ff <= 1'b1;
      mi_ff <= 1'b1;
      sck_oe_ff <= 1'b1;
      ss_oe_ff <= 1'b1;
    end
    else if (run)
    begin
      if (m_edge)
        sclk_ff <= !sclk_ff;
      else if (st_ff == IDLE)
        sclk_ff <= 1'b0; // idle level between bytes
      ss_drv_ff <= !(nxt_st != IDLE);
      // master data pin stays driven while enabled and drv_ok, not only in a byte
      mo_ff <= master && enabled && drv_ok ? 1'b0 : 1'b1;
      mi_ff <= sl_sel && drv_ok ? 1'b0 : 1'b1; // drive from select fall
      sck_oe_ff <= !(master && enabled);
      ss_oe_ff <= !ss_is_out;
    end
  end
  assign sck_out = sclk_ff ^ cpol;
  assign sck_oe_n = sck_oe_ff;
  // data shifted by the first edge appears once the shifter loads
  assign mosi_out = out_bit;
  assign miso_out = out_bit;
  assign mosi_oe_n = mo_ff;
  // only a selected slave drives its data pin, single wire or not
  assign miso_oe_n = mi_ff;
  assign ss_out_n = ss_drv_ff;
  assign ss_oe_n = ss_oe_ff;

  ////////////////////////////////////////////////////////////////////////
  // register file and events; set wins over clear, except that a data write beats the transmit empty set
  // a flag raised in the same cycle as its write-one clear stays set, so
  // software never loses a byte-done or fault event
  // a data write while a byte is in flight only refills the buffer; the
  // shifter takes it when the current byte has ended
  // mode fault drops the master bit so a contended bus is released at once
  // baud bits 7 and 3 do not exist and read back as zero
  // events are qualified by run so a frozen core raises nothing
  wire done_ev = run && last_edge;
  wire fault_ev = run && fault;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl1_ff <= CTRL1_RST;
      ctrl2_ff <= CTRL2_RST;
      baud_ff <= BAUD_RST;
      txd_ff <= ZERO8;
      rxd_ff <= ZERO8;
      imask_ff <= ZERO8;
      iflag_ff <= ZERO8;
      rxf_ff <= 1'b0;
      txe_ff <= 1'b1;
      modf_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl1)
        ctrl1_ff <= wdata;
      else if (fault_ev)
        ctrl1_ff[C1_MASTER_SELECT] <= 1'b0;
      if (wr_ctrl2)
        ctrl2_ff <= wdata;
      if (wr_baud)
        baud_ff <= wdata & 8'h77;
      if (wr_imask)
        imask_ff <= wdata & 8'h03;
      if (wr_data)
      begin
        txd_ff <= wdata;
        txe_ff <= 1'b0;
      end
      else if ((st_ff == IDLE && nxt_st == LEAD && run) || (sl_start && run))
        txe_ff <= 1'b1;
      if (done_ev)
      begin
        rxd_ff <= sh_last;
        rxf_ff <= 1'b1;
      end
      else if (rd_data)
        rxf_ff <= 1'b0;
      modf_ff <= fault_ev | (modf_ff & !wr_ctrl1);
      iflag_ff[IF_DONE] <= done_ev | (iflag_ff[IF_DONE] & !(wr_iflag & wdata[IF_DONE]));
      iflag_ff[IF_FAULT] <= fault_ev | (iflag_ff[IF_FAULT] & !(wr_iflag & wdata[IF_FAULT]));
    end
  end

  // read mux, registered so data stand in the next cycle only
  // reads have no side effect here; the receive full flag clears from the
  // data read strobe in the event process
  logic [7:0] rmux;
  always_comb
  begin
    case (addr)
      ADDR_CTRL1: rmux = ctrl1_ff;
      ADDR_CTRL2: rmux = ctrl2_ff & 8'h1B;
      ADDR_BAUD: rmux = baud_ff;
      ADDR_STATUS: rmux = status_val;
      ADDR_DATA: rmux = rxd_ff;
      ADDR_IMASK: rmux = imask_ff;
      ADDR_IFLAG: rmux = iflag_ff;
      default: rmux = ZERO8;
    endcase
  end
  // read data and interrupt level both leave from flops
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata <= ZERO8;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      rdata <= rd_stb ? rmux : ZERO8;
      irq <= |(iflag_ff & imask_ff);
    end
  end
endmodule // spi_core

// ### src/spi_pkg.sv
// Operation
// - fault-detect enable ignored as slave; master: 0 frees select pin, 1 uses it
// - in single-wire mode, bidir output enable switches the data driver on or off
// - single-wire mode uses master data pin as master, slave data pin as slave
// - halt-in-wait stops block clocks in wait mode, otherwise they keep running; here only the transfer logic halts, the register port keeps running
// - prescale field bits 6:4 divides bus clock by value plus one
// - rate field bits 2:0 divides prescaler output by 2 to the value plus one
// - baud rate register may be read and written at any time
// - status bits 6,3,2,1,0 read zero; status writes do nothing
// - master drives select low half period before transfer, high after bit eight
// - phase 1: slave drives data on select fall, first edge shifts first bit out
// - phase 1: second edge samples the incoming data on both ends
// - phase 1: later alternate edges shift in the sampled bit and present the next
// - phase 1: slave accepts back-to-back transfers without select going high
// - phase 0: bit one starts at select, bit eight ends at last clock edge
package spi_pkg;
  localparam logic [2:0] ADDR_CTRL1 = 3'h0;
  localparam logic [2:0] ADDR_CTRL2 = 3'h1;
  localparam logic [2:0] ADDR_BAUD = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h4;
  localparam logic [2:0] ADDR_IMASK = 3'h5;
  localparam logic [2:0] ADDR_IFLAG = 3'h6;
  // control one fields
  localparam int C1_MASTER_SELECT = 4;
  localparam int C1_CPOL = 3;
  localparam int C1_CLOCK_PHASE = 2;
  localparam int C1_SELECT_OUTPUT_ENABLE = 1;
  localparam int C1_LSBFE = 0;
  localparam int C1_EN = 6;
  // control two fields
  localparam int C2_MODF = 4;
  localparam int C2_BIDIR_OUTPUT_ENABLE = 3;
  localparam int C2_SWAI = 1;
  localparam int C2_SINGLE_WIRE_SELECT = 0;
  // status fields
  localparam int ST_RXF = 7;
  localparam int ST_TXE = 5;
  localparam int ST_MODF = 4;
  localparam logic [7:0] ST_IMPL_MASK = 8'hB0;
  // interrupt flag fields
  localparam int IF_DONE = 0;
  localparam int IF_FAULT = 1;
  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam int BITS = 8;
  typedef enum logic [1:0] {IDLE = 2'b00, LEAD = 2'b01, SHIFT = 2'b11, TRAIL = 2'b10} state_t;
endpackage

// ### dv/spi_core_assertions.sv
`timescale 1ns/1ps
module spi_core_checker
  import spi_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cpu_wait,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic sck_out,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic ss_out_n,
  input wire logic ss_oe_n
);
  logic [7:0] c1_ff, c2_ff, br_ff;
  logic [10:0] hc_ff;
  logic [4:0] ne_ff;
  logic sck_q_ff;
  // half bit period in bus cycles, from the mirrored baud fields
  wire [10:0] half = ({8'h00, br_ff[6:4]} + 11'h001) << br_ff[2:0];
  wire frz = cpu_wait & c2_ff[C2_SWAI];
  wire tgl = sck_out != sck_q_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////////
  // register mirrors, snooped from the port so no hierarchy peeking
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) c1_ff <= CTRL1_RST;
    else if (wr_stb && addr == ADDR_CTRL1) c1_ff <= wdata;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) c2_ff <= CTRL2_RST;
    else if (wr_stb && addr == ADDR_CTRL2) c2_ff <= wdata;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) br_ff <= BAUD_RST;
    else if (wr_stb && addr == ADDR_BAUD) br_ff <= wdata & 8'h77;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) sck_q_ff <= 1'b0;
    else sck_q_ff <= sck_out;
  // cycles since last clock edge; held in wait so a freeze is not a slip
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) hc_ff <= 11'h000;
    else if (ss_out_n) hc_ff <= 11'h000;
    else if (!frz) hc_ff <= tgl ? 11'h001 : hc_ff + 11'h001;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) ne_ff <= 5'h00;
    else if (ss_out_n) ne_ff <= 5'h00;
    else if (tgl) ne_ff <= ne_ff + 5'h01;
  ////////////////////////////////////////////////////////////////////////////
  property p_sel_pin;
    c1_ff[C1_EN] && c1_ff[C1_MASTER_SELECT] && $stable(c2_ff) && $stable(c1_ff)
      |-> ss_oe_n == !(c2_ff[C2_MODF] && c1_ff[C1_SELECT_OUTPUT_ENABLE]);
  endproperty
  a_sel_pin: assert property (p_sel_pin) else $error("select pin use");
  property p_bidir_off;
    c1_ff[C1_EN] && c2_ff[C2_SINGLE_WIRE_SELECT] && !c2_ff[C2_BIDIR_OUTPUT_ENABLE] && $stable(c2_ff)
      |-> (c1_ff[C1_MASTER_SELECT] ? mosi_oe_n : miso_oe_n);
  endproperty
  a_bidir_off: assert property (p_bidir_off) else $error("bidir pin driven");
  property p_one_wire;
    c1_ff[C1_EN] && c1_ff[C1_MASTER_SELECT] && c2_ff[C2_SINGLE_WIRE_SELECT] && $stable(c2_ff)
      |-> miso_oe_n && (mosi_oe_n == !c2_ff[C2_BIDIR_OUTPUT_ENABLE]);
  endproperty
  a_one_wire: assert property (p_one_wire) else $error("single wire pin");
  property p_wait_halt;
    frz |=> $stable(sck_out) && $stable(ss_out_n);
  endproperty
  a_wait_halt: assert property (p_wait_halt) else $error("ran in wait");
  property p_half;
    !ss_out_n && tgl |-> hc_ff == half;
  endproperty
  a_half: assert property (p_half) else $error("half period length");
  property p_baud_rd;
    $past(rd_stb) && $past(addr) == ADDR_BAUD |-> rdata == br_ff;
  endproperty
  a_baud_rd: assert property (p_baud_rd) else $error("baud readback");
  property p_status_rd;
    $past(rd_stb) && $past(addr) == ADDR_STATUS |-> (rdata & ~ST_IMPL_MASK) == ZERO8;
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status spare bits");
  property p_frame_end;
    $rose(ss_out_n) |-> hc_ff == half && ne_ff == 5'h10;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame end");
  property p_idle_clk;
    c1_ff[C1_MASTER_SELECT] && ss_out_n && $past(ss_out_n) |-> sck_out == c1_ff[C1_CPOL];
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");
endmodule // spi_core_checker

// ### dv/spi_slave_model.sv
`timescale 1ns/1ps
// idle-low clock only; msb first
module spi_slave_model
(
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic clock_phase,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  logic [7:0] sh;
  initial miso = 1'b0;
  // phase 1 drives junk until the first edge, phase 0 shows bit 7 at once
  always @(negedge ss_n)
  begin
    sh = clock_phase ? tx_byte : {tx_byte[6:0], 1'b0};
    miso = clock_phase ? ~miso : tx_byte[7];
  end
  always @(posedge sck)
    if (!ss_n && clock_phase) {miso, sh} = {sh, 1'b0};
    else if (!ss_n) rx_byte = {rx_byte[6:0], mosi};
  always @(negedge sck)
    if (!ss_n && clock_phase) rx_byte = {rx_byte[6:0], mosi};
    else if (!ss_n) {miso, sh} = {sh, 1'b0};
  // released line must not keep the last bit
  always @(posedge ss_n) miso = ~miso;
endmodule // spi_slave_model

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
  import spi_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic cpu_wait = 1'b0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic clock_phase = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] s_tx = 8'h00;
  logic [7:0] rdata, got, s_rx;
  logic irq, sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
  logic ss_out_n, ss_oe_n, s_miso;
  int mismatches = 0;
  int checks_done = 0;
  `define CHK(n, e, g) \
    begin \
      checks_done++; \
      if ((g) !== (e)) \
      begin \
        mismatches++; \
        $display("[ERR] %s exp %h got %h", n, e, g); \
      end \
    end
  spi_core dut (.sys_clk, .rstn, .clk_en(1'b1), .cpu_wait, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .irq, .sck_in(1'b0), .sck_out, .sck_oe_n, .mosi_in(mosi_out), .mosi_out,
    .mosi_oe_n, .miso_in(s_miso), .miso_out, .miso_oe_n, .ss_in_n(1'b1), .ss_out_n, .ss_oe_n);
  spi_slave_model peer (.sck(sck_out), .ss_n(ss_out_n), .mosi(mosi_out), .clock_phase,
    .tx_byte(s_tx), .miso(s_miso), .rx_byte(s_rx));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  // data taken just after the edge that launches the answer cycle
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e, input string n);
    rd(a, got);
    `CHK(n, e, got)
  endtask
  task automatic wait_irq(input logic lvl);
    int n = 0;
    while (irq !== lvl && n < 5000)
    begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("irq", lvl, irq)
  endtask
  // one master byte: en, master, select output, chosen phase
  task automatic xfer(input logic [7:0] br, input logic ph, input logic [7:0] d,
                      input logic [7:0] s);
    clock_phase = ph;
    s_tx = s;
    wr(ADDR_BAUD, br);
    wr(ADDR_CTRL1, 8'h52 | {5'h00, ph, 2'h0});
    wr(ADDR_DATA, d);
    chk_rd(ADDR_BAUD, br, "baud busy");
    wait_irq(1'b1);
    `CHK("peer rx", d, s_rx)
    chk_rd(ADDR_DATA, s, "rx byte");
    wr(ADDR_IFLAG, 8'h01);
    wait_irq(1'b0);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    chk_rd(ADDR_CTRL1, CTRL1_RST, "ctrl1 reset");
    chk_rd(ADDR_CTRL2, CTRL2_RST, "ctrl2 reset");
    chk_rd(ADDR_BAUD, BAUD_RST, "baud reset");
    chk_rd(3'h7, ZERO8, "unmapped");
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, got);
    `CHK("status spare", ZERO8, got & ~ST_IMPL_MASK)
    wr(ADDR_IMASK, 8'h01);
    wr(ADDR_CTRL2, 8'h10);
    xfer(8'h02, 1'b0, 8'hA5, 8'h3C);
    cpu_wait <= 1'b1;
    xfer(8'h70, 1'b1, 8'h5A, 8'hC3);
    cpu_wait <= 1'b0;
    xfer(8'h12, 1'b0, 8'h81, 8'h7E);
    xfer(8'h05, 1'b1, 8'h01, 8'h80);
    // halt in wait: a whole frame's time passes with nothing done
    wr(ADDR_CTRL2, 8'h12);
    wr(ADDR_DATA, 8'h96);
    cpu_wait <= 1'b1;
    repeat (2000) @(posedge sys_clk);
    `CHK("frozen irq", 1'b0, irq)
    cpu_wait <= 1'b0;
    wait_irq(1'b1);
    wr(ADDR_IMASK, 8'h00);
    wait_irq(1'b0);
    chk_rd(ADDR_IFLAG, 8'h01, "flag held");
    wr(ADDR_IFLAG, 8'h01);
    chk_rd(ADDR_IFLAG, ZERO8, "flag cleared");
    repeat (40) @(posedge sys_clk);
    wr(ADDR_CTRL2, 8'h11);
    repeat (2) @(posedge sys_clk);
    `CHK("data pin in", 1'b1, mosi_oe_n)
    `CHK("other pin off", 1'b1, miso_oe_n)
    wr(ADDR_CTRL2, 8'h19);
    repeat (2) @(posedge sys_clk);
    `CHK("data pin out", 1'b0, mosi_oe_n)
    `CHK("select out", 1'b0, ss_oe_n)
    `CHK("clock pin out", 1'b0, sck_oe_n)
    wr(ADDR_CTRL1, 8'h40);
    wr(ADDR_CTRL2, 8'h01);
    repeat (4) @(posedge sys_clk);
    `CHK("select slave", 1'b1, ss_oe_n)
    `CHK("slave pin off", 1'b1, miso_oe_n)
    final_report();
  end
  // watchdog well beyond the longest expected run
  initial
  begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule // tb
bind spi_core spi_core_checker chk (.sys_clk, .rstn, .cpu_wait, .addr, .wdata, .wr_stb,
  .rd_stb, .rdata, .irq, .sck_out, .mosi_oe_n, .miso_oe_n, .ss_out_n, .ss_oe_n);
